/* File: hw/aad_consts.svh */
// Named constants of the accessory attach detect block.
// Assumes a 50 MHz system clock; all times are in milliseconds.
`ifndef AAD_CONSTS_SVH
`define AAD_CONSTS_SVH

`define AAD_CLK_KHZ      50000
`define AAD_TMR_W        26
`define AAD_CHK_W        2
`define AAD_I2C_ADDR     7'h25
`define AAD_RW_READ      1'b1
`define AAD_BIT_LAST     3'h7
`define AAD_T_I2CRST_MS  30
`define AAD_T_SDP_MS     120
`define AAD_T_CHG_MS     160
`define AAD_T_CARKIT_MS  140
`define AAD_T_IDWIN_MS   50
`define AAD_ID_CHECKS    3
`define AAD_T_DCD_MS     600

`endif

/* File: hw/aad_pkg.sv */
// Types shared by the attach detect top and its timer.
// Assumes aad_consts.svh is on the include path.
`include "aad_consts.svh"

package aad_pkg;

    typedef logic [`AAD_TMR_W-1:0] aad_cnt_t;

    typedef enum logic [2:0] {
        PT_NONE   = 3'b000,
        PT_SDP    = 3'b001,
        PT_CDP    = 3'b010,
        PT_DCP    = 3'b011,
        PT_CARKIT = 3'b100
    } aad_port_e;

    typedef enum logic [2:0] {
        A_IDLE   = 3'b000,
        A_VBUS   = 3'b001,
        A_ON     = 3'b010,
        A_IDWIN  = 3'b011,
        A_IDDONE = 3'b100
    } aad_att_e;

    typedef enum logic [2:0] {
        I_IDLE  = 3'b000,
        I_ADDR  = 3'b001,
        I_ACK   = 3'b010,
        I_WDATA = 3'b011,
        I_RDATA = 3'b100,
        I_RACK  = 3'b101
    } aad_i2c_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } aad_i2c_pins_s;

    typedef struct packed {
        logic fet_close;
        logic usb_close;
    } aad_sw_s;

    typedef struct packed {
        aad_cnt_t count;
        logic     busy;
        logic     done;
    } aad_tmr_s;

    typedef struct packed {
        aad_att_e                att;
        aad_port_e               pt;
        aad_sw_s                 auto_sw;
        aad_sw_s                 sw_o;
        logic                    vbus_p;
        logic                    lowb_p;
        logic [`AAD_CHK_W-1:0]   checks;
        logic                    carkit;
        logic                    accessory;
        logic                    dcd_to;
        logic                    int_n;
        logic                    soft_rst;
        aad_i2c_e                ist;
        logic                    scl_p;
        logic                    sda_p;
        logic [7:0]              shreg;
        logic [2:0]              bitcnt;
        logic                    full;
        logic                    rw;
        logic [7:0]              tx;
        logic                    sda_o;
        logic                    sda_oe_n;
    } aad_state_s;

endpackage

/* File: hw/aad_timer.sv */
// Restartable delay counter with a one-cycle done pulse.
// Assumes start and cancel are synchronous to clk_sys; cancel wins.
`include "aad_consts.svh"

module aad_timer (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             start,
    input  wire logic             cancel,
    input  wire aad_pkg::aad_cnt_t limit,
    output aad_pkg::aad_cnt_t     count,
    output logic                  busy,
    output logic                  done
);

    aad_pkg::aad_tmr_s t_r;
    aad_pkg::aad_tmr_s t_nxt;

    always_comb begin
        t_nxt      = t_r;
        t_nxt.done = 1'b0;
        if (cancel) begin
            t_nxt.busy = 1'b0;
        end else if (start) begin
            t_nxt.count = '0;
            t_nxt.busy  = 1'b1;
        end else if (t_r.busy) begin
            t_nxt.count = t_r.count + aad_pkg::aad_cnt_t'(1);
            if (t_nxt.count >= limit) begin
                t_nxt.busy = 1'b0;
                t_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            t_r <= '0;
        end else if (ce) begin
            t_r <= t_nxt;
        end
    end

    assign count = t_r.count;
    assign busy  = t_r.busy;
    assign done  = t_r.done;

endmodule

/* File: hw/aad_top.sv */
// Attach detect sequencing: bus power and ID pin timing, switch control,
// DCD timeout, ID resistor accessory flag and a minimal I2C address slave.
// Assumes analog detectors deliver clean levels synchronous to clk_sys.
`include "aad_consts.svh"

// Function
// - The device acknowledges I2C address 0100101 and the low bit picks read or write.
// - SDA and SCL both low for 30 ms or more reset the device.
// - A standard port closes the charger FET and USB switches 120 ms after bus power.
// - A charging or dedicated charging port closes the charger FET 160 ms after bus power.
// - A type-1 or type-2 car kit is recognised 140 ms after bus power.
// - An ID-only accessory without bus power pulls the interrupt low about 150 ms on.
// - ID detection uses a 50 ms window repeated over three consecutive checks.
// - The data contact wait ends after a 600 ms nominal timeout.
// - The attach timings hold in automatic mode, manual switch enable cleared.
// - Automatically, a dedicated charging port never gets the USB data switches.
// - Manual switch enable at 1 makes the switches follow the manual setting.
module aad_top #(
    parameter aad_pkg::aad_cnt_t           I2CRST_CYC = aad_pkg::aad_cnt_t'(
                                               `AAD_T_I2CRST_MS * `AAD_CLK_KHZ),
    parameter aad_pkg::aad_cnt_t           SDP_CYC    = aad_pkg::aad_cnt_t'(
                                               `AAD_T_SDP_MS * `AAD_CLK_KHZ),
    parameter aad_pkg::aad_cnt_t           CHG_CYC    = aad_pkg::aad_cnt_t'(
                                               `AAD_T_CHG_MS * `AAD_CLK_KHZ),
    parameter aad_pkg::aad_cnt_t           CARKIT_CYC = aad_pkg::aad_cnt_t'(
                                               `AAD_T_CARKIT_MS * `AAD_CLK_KHZ),
    parameter aad_pkg::aad_cnt_t           IDWIN_CYC  = aad_pkg::aad_cnt_t'(
                                               `AAD_T_IDWIN_MS * `AAD_CLK_KHZ),
    parameter aad_pkg::aad_cnt_t           DCD_CYC    = aad_pkg::aad_cnt_t'(
                                               `AAD_T_DCD_MS * `AAD_CLK_KHZ),
    parameter logic [`AAD_CHK_W-1:0]       ID_CHECKS  = `AAD_CHK_W'(`AAD_ID_CHECKS)
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire aad_pkg::aad_i2c_pins_s i2c_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    input  wire logic                   bus_power_in,
    input  wire logic                   id_pin_float,
    input  wire logic                   id_match,
    input  wire aad_pkg::aad_port_e     port_type,
    input  wire logic                   data_contact,
    input  wire logic                   dcd_timeout_enable,
    input  wire logic                   manual_switch_enable,
    input  wire aad_pkg::aad_sw_s       manual_sw,
    input  wire logic                   interrupt_ack,
    output aad_pkg::aad_sw_s            sw_out,
    output logic                        carkit_detected,
    output logic                        accessory_attached,
    output logic                        dcd_timeout,
    output logic                        interrupt_out_n,
    output logic                        soft_reset
);

    if (ID_CHECKS == '0 || IDWIN_CYC == '0 || DCD_CYC == '0 || I2CRST_CYC == '0 ||
        SDP_CYC > CHG_CYC || CARKIT_CYC > CHG_CYC) begin : g_bad_param
        $error("aad_top: zero count or attach delay beyond the charger delay");
    end

    aad_pkg::aad_state_s r;
    aad_pkg::aad_state_s n;

    logic              srst;
    logic              vbus_rise;
    logic              both_low;
    logic              scl_rise;
    logic              scl_fall;
    logic              i2c_start;
    logic              i2c_stop;
    logic              m_start;
    logic              m_cancel;
    aad_pkg::aad_cnt_t m_limit;
    aad_pkg::aad_cnt_t m_cnt;
    logic              m_busy;
    logic              m_done;
    logic              d_start;
    logic              d_cancel;
    logic              d_done;
    logic              r_done;

    // Soft reset is a registered pulse, so it cannot glitch the timers
    assign srst      = rst | r.soft_rst;
    assign vbus_rise = bus_power_in & ~r.vbus_p;
    assign both_low  = ~i2c_in.scl & ~i2c_in.sda;
    assign scl_rise  = i2c_in.scl & ~r.scl_p;
    assign scl_fall  = ~i2c_in.scl & r.scl_p;
    assign i2c_start = i2c_in.scl & r.scl_p & r.sda_p & ~i2c_in.sda;
    assign i2c_stop  = i2c_in.scl & r.scl_p & ~r.sda_p & i2c_in.sda;

    function automatic aad_pkg::aad_cnt_t target_of(input aad_pkg::aad_port_e pt);
        case (pt)
            aad_pkg::PT_SDP:    target_of = SDP_CYC;
            aad_pkg::PT_CARKIT: target_of = CARKIT_CYC;
            default:            target_of = CHG_CYC;
        endcase
    endfunction

    always_comb begin
        n          = r;
        n.soft_rst = 1'b0;
        n.vbus_p   = bus_power_in;
        n.lowb_p   = both_low;
        n.scl_p    = i2c_in.scl;
        n.sda_p    = i2c_in.sda;
        n.sda_o    = 1'b0;
        m_start    = 1'b0;
        m_cancel   = 1'b0;
        m_limit    = (r.att == aad_pkg::A_IDWIN) ? IDWIN_CYC : CHG_CYC;
        d_start    = vbus_rise & dcd_timeout_enable;
        d_cancel   = data_contact | ~bus_power_in;
        if (r_done) begin
            n.soft_rst = 1'b1;
        end
        if (interrupt_ack) begin
            n.int_n = 1'b1;
        end
        case (r.att)
            aad_pkg::A_IDLE: begin
                if (vbus_rise) begin
                    n.att   = aad_pkg::A_VBUS;
                    m_start = 1'b1;
                    m_limit = CHG_CYC;
                end else if (!bus_power_in && !id_pin_float) begin
                    n.att    = aad_pkg::A_IDWIN;
                    n.checks = '0;
                    m_start  = 1'b1;
                    m_limit  = IDWIN_CYC;
                end
            end
            aad_pkg::A_VBUS: begin
                if (!bus_power_in) begin
                    n.att    = aad_pkg::A_IDLE;
                    m_cancel = 1'b1;
                end else if (port_type != aad_pkg::PT_NONE &&
                             m_cnt >= target_of(port_type)) begin
                    n.pt  = port_type;
                    n.att = aad_pkg::A_ON;
                    case (port_type)
                        aad_pkg::PT_SDP,
                        aad_pkg::PT_CDP: n.auto_sw = '{fet_close: 1'b1, usb_close: 1'b1};
                        aad_pkg::PT_DCP: n.auto_sw = '{fet_close: 1'b1, usb_close: 1'b0};
                        default: begin
                            n.auto_sw = '{fet_close: 1'b1, usb_close: 1'b0};
                            n.carkit  = 1'b1;
                        end
                    endcase
                end
            end
            aad_pkg::A_ON: begin
                if (!bus_power_in) begin
                    n.att = aad_pkg::A_IDLE;
                end
            end
            aad_pkg::A_IDWIN: begin
                if (vbus_rise) begin
                    n.att   = aad_pkg::A_VBUS;
                    m_start = 1'b1;
                    m_limit = CHG_CYC;
                end else if (id_pin_float) begin
                    n.att    = aad_pkg::A_IDLE;
                    m_cancel = 1'b1;
                end else if (m_done) begin
                    m_start = 1'b1;
                    if (!id_match) begin
                        n.checks = '0;
                    end else if (r.checks == ID_CHECKS - `AAD_CHK_W'(1)) begin
                        m_start     = 1'b0;
                        n.att       = aad_pkg::A_IDDONE;
                        n.accessory = 1'b1;
                        n.int_n     = 1'b0;
                    end else begin
                        n.checks = r.checks + `AAD_CHK_W'(1);
                    end
                end
            end
            aad_pkg::A_IDDONE: begin
                if (id_pin_float) begin
                    n.att       = aad_pkg::A_IDLE;
                    n.accessory = 1'b0;
                end
            end
            default: n.att = aad_pkg::A_IDLE;
        endcase
        if (!bus_power_in) begin
            n.auto_sw = '0;
            n.carkit  = 1'b0;
            n.dcd_to  = 1'b0;
            n.pt      = aad_pkg::PT_NONE;
        end else if (d_done) begin
            n.dcd_to = 1'b1;
        end
        n.sw_o = manual_switch_enable ? manual_sw : n.auto_sw;

        if (scl_rise && r.ist != aad_pkg::I_IDLE) begin
            n.shreg  = {r.shreg[6:0], i2c_in.sda};
            n.bitcnt = r.bitcnt + 3'h1;
            n.full   = (r.bitcnt == `AAD_BIT_LAST);
            if (r.ist == aad_pkg::I_RACK) begin
                n.ist = i2c_in.sda ? aad_pkg::I_IDLE : aad_pkg::I_ACK;
            end
        end
        if (scl_fall) begin
            case (r.ist)
                aad_pkg::I_ADDR: begin
                    if (r.full) begin
                        n.full = 1'b0;
                        if (r.shreg[7:1] == `AAD_I2C_ADDR) begin
                            n.rw       = r.shreg[0];
                            n.ist      = aad_pkg::I_ACK;
                            n.sda_oe_n = 1'b0;
                        end else begin
                            n.ist = aad_pkg::I_IDLE;
                        end
                    end
                end
                aad_pkg::I_WDATA: begin
                    if (r.full) begin
                        n.full     = 1'b0;
                        n.ist      = aad_pkg::I_ACK;
                        n.sda_oe_n = 1'b0;
                    end
                end
                aad_pkg::I_ACK: begin
                    n.sda_oe_n = 1'b1;
                    n.bitcnt   = '0;
                    n.full     = 1'b0;
                    if (r.rw == `AAD_RW_READ) begin
                        n.tx       = {r.accessory, r.carkit, r.dcd_to, r.sw_o.fet_close,
                                      r.sw_o.usb_close, r.vbus_p, ~r.int_n,
                                      r.att == aad_pkg::A_VBUS};
                        n.sda_oe_n = n.tx[7];
                        n.ist      = aad_pkg::I_RDATA;
                    end else begin
                        n.ist = aad_pkg::I_WDATA;
                    end
                end
                aad_pkg::I_RDATA: begin
                    if (r.full) begin
                        n.full     = 1'b0;
                        n.sda_oe_n = 1'b1;
                        n.ist      = aad_pkg::I_RACK;
                    end else begin
                        n.tx       = {r.tx[6:0], 1'b0};
                        n.sda_oe_n = r.tx[6];
                    end
                end
                default: ;
            endcase
        end
        // Start and stop override any byte in flight
        if (i2c_start) begin
            n.ist      = aad_pkg::I_ADDR;
            n.bitcnt   = '0;
            n.full     = 1'b0;
            n.sda_oe_n = 1'b1;
        end else if (i2c_stop) begin
            n.ist      = aad_pkg::I_IDLE;
            n.sda_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r          <= '0;
            r.int_n    <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else if (ce) begin
            r <= n;
        end
    end

    aad_timer u_main (.clk_sys(clk_sys), .rst(srst), .ce(ce), .start(m_start),
                      .cancel(m_cancel), .limit(m_limit), .count(m_cnt), .busy(m_busy),
                      .done(m_done));
    aad_timer u_dcd  (.clk_sys(clk_sys), .rst(srst), .ce(ce), .start(d_start),
                      .cancel(d_cancel), .limit(DCD_CYC), .count(), .busy(), .done(d_done));
    aad_timer u_i2c  (.clk_sys(clk_sys), .rst(srst), .ce(ce), .start(both_low & ~r.lowb_p),
                      .cancel(~both_low), .limit(I2CRST_CYC), .count(), .busy(),
                      .done(r_done));

    assign sda_out            = r.sda_o;
    assign sda_oe_n           = r.sda_oe_n;
    assign sw_out             = r.sw_o;
    assign carkit_detected    = r.carkit;
    assign accessory_attached = r.accessory;
    assign dcd_timeout        = r.dcd_to;
    assign interrupt_out_n    = r.int_n;
    assign soft_reset         = r.soft_rst;

    addr_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && scl_fall && !i2c_start && r.ist == aad_pkg::I_ADDR && r.full &&
        r.shreg[7:1] == `AAD_I2C_ADDR |=> !sda_oe_n && r.ist == aad_pkg::I_ACK)
        else $error("matching address not acknowledged");

    addr_nack_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && scl_fall && !i2c_start && r.ist == aad_pkg::I_ADDR && r.full &&
        r.shreg[7:1] != `AAD_I2C_ADDR |=> sda_oe_n && r.ist == aad_pkg::I_IDLE)
        else $error("foreign address acknowledged");

    sequence bus_rst_s;
        r_done && ce ##1 soft_reset;
    endsequence
    bus_rst_a: assert property (@(posedge clk_sys) disable iff (rst)
        bus_rst_s |=> sw_out == '0 && interrupt_out_n && !accessory_attached)
        else $error("bus-low reset did not clear the device");

    sdp_close_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && r.att == aad_pkg::A_VBUS && bus_power_in && port_type == aad_pkg::PT_SDP &&
        m_cnt >= SDP_CYC && !manual_switch_enable |=> sw_out.fet_close && sw_out.usb_close)
        else $error("standard port switches not closed");

    chg_early_a: assert property (@(posedge clk_sys) disable iff (srst)
        r.att == aad_pkg::A_VBUS && ce && m_cnt < CHG_CYC - aad_pkg::aad_cnt_t'(1) &&
        (port_type == aad_pkg::PT_CDP || port_type == aad_pkg::PT_DCP) |=> !r.auto_sw.fet_close)
        else $error("charger FET closed before its delay");

    carkit_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(carkit_detected) |-> $past(m_cnt) >= CARKIT_CYC)
        else $error("car kit recognised early");

    dcp_data_a: assert property (@(posedge clk_sys) disable iff (srst)
        r.pt == aad_pkg::PT_DCP |-> !r.auto_sw.usb_close && r.auto_sw.fet_close)
        else $error("data switches closed for dedicated charger");

    man_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && manual_switch_enable |=> sw_out == $past(manual_sw))
        else $error("switches ignore manual setting");

    auto_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !manual_switch_enable |=> sw_out == r.auto_sw)
        else $error("switches ignore automatic setting");

    id_int_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(accessory_attached) |-> !interrupt_out_n)
        else $error("accessory without interrupt");

    id_checks_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(accessory_attached) |-> $past(r.checks) == ID_CHECKS - `AAD_CHK_W'(1) &&
        $past(m_done) && $past(id_match))
        else $error("accessory reported without full check count");

    dcd_to_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && d_done && bus_power_in |=> dcd_timeout)
        else $error("DCD timeout not flagged");

    restart_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && r.att == aad_pkg::A_IDLE && vbus_rise |=> m_busy && m_cnt == '0)
        else $error("attach timer not restarted");

endmodule

/* File: verification/aad_host_model.sv */
// Host side model: I2C master on an open-drain SDA with pull-up.
// Assumes the device pulls SDA low when sda_oe_n is low.
module aad_host_model (
    input  wire logic             clk_sys,
    input  wire logic             sda_oe_n,
    output aad_pkg::aad_i2c_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    // Wired-and line, released level is high
    assign pins = '{scl: scl, sda: sda_m & sda_oe_n};
    task automatic step(input logic c, input logic d);
        @(posedge clk_sys);
        scl <= c;
        sda_m <= d;
        repeat (3) @(posedge clk_sys);
    endtask
    // Address byte MSB first, ninth clock samples ACK
    task automatic addr(input logic [7:0] b, output logic ack, output logic [7:0] rd);
        rd = 8'hFF;
        step(1'b1, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        ack = ~pins.sda;
        // A read takes one status byte and ends it with a NACK, else the slave holds SDA
        if (b[0] && ack) begin
            for (int i = 7; i >= 0; i--) begin
                step(1'b0, 1'b1);
                step(1'b1, 1'b1);
                rd[i] = pins.sda;
            end
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
        end
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Both lines held low to reset the device
    task automatic bus_low(input int n);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        repeat (n) @(posedge clk_sys);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
endmodule

/* File: verification/tb_aad_top.sv */
// Self-checking bench for aad_top with shortened timing parameters.
// Assumes aad_pkg compiled first; host model drives the I2C lines.
module tb_aad_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SDP = 40, CHG = 60, CK = 50, IDW = 10, DCD = 100, BRST = 20;
    logic               clk_sys = 0, rst = 1, ce = 1, bus_power_in = 0, id_pin_float = 1;
    logic               id_match = 0, data_contact = 0, dcd_timeout_enable = 0, ack;
    logic               manual_switch_enable = 0, interrupt_ack = 0, sda_out, sda_oe_n;
    logic               carkit_detected, accessory_attached, dcd_timeout;
    logic               interrupt_out_n, soft_reset;
    logic [7:0]         rd;
    aad_pkg::aad_port_e port_type = aad_pkg::PT_NONE;
    aad_pkg::aad_sw_s   manual_sw = 2'h0, sw_out;
    aad_pkg::aad_i2c_pins_s i2c_in;
    int                 mismatches = 0, n_tests = 0, n;

    aad_host_model aad_host_model_i (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .pins(i2c_in));
    aad_top #(.I2CRST_CYC(26'(BRST)), .SDP_CYC(26'(SDP)), .CHG_CYC(26'(CHG)),
        .CARKIT_CYC(26'(CK)), .IDWIN_CYC(26'(IDW)), .DCD_CYC(26'(DCD)), .ID_CHECKS(2'h3)
    ) aad_top_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .i2c_in(i2c_in), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .bus_power_in(bus_power_in), .id_pin_float(id_pin_float),
        .id_match(id_match), .port_type(port_type), .data_contact(data_contact),
        .dcd_timeout_enable(dcd_timeout_enable), .manual_switch_enable(manual_switch_enable),
        .manual_sw(manual_sw), .interrupt_ack(interrupt_ack), .sw_out(sw_out),
        .carkit_detected(carkit_detected), .accessory_attached(accessory_attached),
        .dcd_timeout(dcd_timeout), .interrupt_out_n(interrupt_out_n), .soft_reset(soft_reset));

    initial forever #10 clk_sys = ~clk_sys;

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Latency must fall in [lo, hi]; a spent wait ends the run
    task automatic chk_in(input int v, input int lo, input int hi, input string m);
        chk(8'(v >= lo && v <= hi), 8'h01, m);
        if (v >= 1000) complete_run();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic attach(input aad_pkg::aad_port_e pt, input logic [1:0] sw,
                          input logic ck, input int t);
        port_type <= pt;
        bus_power_in <= 1'b1;
        for (n = 0; sw_out === 2'h0 && n < 1000; n++) cyc(1);
        chk_in(n, t, t + 5, "attach delay");
        cyc(1);
        chk(8'(sw_out), 8'(sw), "switch state");
        chk(8'(carkit_detected), 8'(ck), "car kit flag");
        bus_power_in <= 1'b0;
        port_type <= aad_pkg::PT_NONE;
        cyc(3);
        chk(8'(sw_out), 8'h00, "detach");
    endtask
    task automatic id_accessory();
        id_pin_float <= 1'b0;
        id_match <= 1'b1;
        for (n = 0; interrupt_out_n !== 1'b0 && n < 1000; n++) cyc(1);
        chk_in(n, 3 * IDW, 3 * IDW + 8, "id detect delay");
        chk(8'(accessory_attached), 8'h01, "accessory flag");
        interrupt_ack <= 1'b1;
        cyc(1);
        interrupt_ack <= 1'b0;
        id_pin_float <= 1'b1;
        cyc(3);
        chk(8'(interrupt_out_n), 8'h01, "interrupt release");
        chk(8'(accessory_attached), 8'h00, "accessory clear");
    endtask
    task automatic dcd_case();
        dcd_timeout_enable <= 1'b1;
        bus_power_in <= 1'b1;
        for (n = 0; dcd_timeout !== 1'b1 && n < 1000; n++) cyc(1);
        chk_in(n, DCD, DCD + 5, "dcd timeout");
        bus_power_in <= 1'b0;
        dcd_timeout_enable <= 1'b0;
        cyc(3);
        // Data-line contact present as bus power rises must keep the wait from starting
        dcd_timeout_enable <= 1'b1;
        data_contact <= 1'b1;
        bus_power_in <= 1'b1;
        cyc(DCD + 10);
        chk(8'(dcd_timeout), 8'h00, "dcd cancelled by contact");
        bus_power_in <= 1'b0;
        dcd_timeout_enable <= 1'b0;
        data_contact <= 1'b0;
        cyc(3);
    endtask
    task automatic manual_case();
        manual_switch_enable <= 1'b1;
        manual_sw <= 2'h1;
        cyc(3);
        chk(8'(sw_out), 8'h01, "manual switches");
        ce <= 1'b0;
        manual_sw <= 2'h2;
        cyc(3);
        chk(8'(sw_out), 8'h01, "frozen by clock enable");
        ce <= 1'b1;
        cyc(3);
        chk(8'(sw_out), 8'h02, "manual switches after enable");
        manual_switch_enable <= 1'b0;
        cyc(3);
        chk(8'(sw_out), 8'h00, "automatic again");
    endtask
    task automatic bus_reset_case();
        fork
            aad_host_model_i.bus_low(BRST + 10);
            begin
                for (n = 0; soft_reset !== 1'b1 && n < 1000; n++) cyc(1);
                // The START step takes four cycles before both lines sit low
                chk_in(n, BRST + 4, BRST + 10, "bus reset");
            end
        join
    endtask

    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(2);
        attach(aad_pkg::PT_SDP, 2'h3, 1'b0, SDP);
        attach(aad_pkg::PT_CDP, 2'h3, 1'b0, CHG);
        attach(aad_pkg::PT_DCP, 2'h2, 1'b0, CHG);
        attach(aad_pkg::PT_CARKIT, 2'h2, 1'b1, CK);
        id_accessory();
        dcd_case();
        manual_case();
        aad_host_model_i.addr(8'h4A, ack, rd);
        chk(8'(ack), 8'h01, "write address ack");
        aad_host_model_i.addr(8'h4B, ack, rd);
        chk(8'(ack), 8'h01, "read address ack");
        chk(rd, 8'h00, "idle status byte");
        chk(8'(sda_out), 8'h00, "sda drive value");
        aad_host_model_i.addr(8'h4C, ack, rd);
        chk(8'(ack), 8'h00, "foreign address");
        bus_reset_case();
        complete_run();
    end
endmodule
